// >>> design/fic_ctrl_regs.sv
// Design: control and target address registers of the flash programming sequencer

module fic_ctrl_regs
    import fic_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        reg_unlocked,
    input  wire logic        cpu_reset_seen,
    input  wire logic        system_reset_seen,
    input  wire logic [1:0]  config_boot_choice,
    input  wire fic_trig_t   prog_trigger,
    input  wire logic        flash_done,
    output logic             flash_start,
    output logic             prog_busy,
    output logic             prog_enable,
    output logic             irq
);

    // Bus phase tracking
    logic        rd_pend_q;      // Read waiting for its data edge
    logic        wr_pend_q;      // Write data phase in progress
    logic [7:0]  rd_addr_q;      // Latched read offset
    logic [7:0]  wr_addr_q;      // Latched write offset
    logic        hreadyout_q;    // Ready toward the bus
    logic        hresp_q;        // Always OKAY
    logic [31:0] hrdata_q;       // Read data

    // Control fields
    logic        func_en_q;      // Programming function enable
    logic        boot_q;         // Boot select and booted status
    logic        boot_init_q;    // Boot bit has been loaded
    logic        app_uen_q;      // Application update enable
    logic        cfg_uen_q;      // Configuration update enable
    logic        ldr_uen_q;      // Loader update enable
    logic        fail_q;         // Sticky fail flag
    logic [31:0] target_q;       // Target address

    // Sequencer and interrupt state
    fic_state_t  state_q;        // Idle or running
    logic        start_q;        // Flash start pulse
    logic        busy_q;         // Trigger bit as seen by software
    logic [1:0]  int_stat_q;     // Sticky events
    logic [1:0]  int_mask_q;     // Event enables
    logic        irq_q;          // Interrupt level

    // Address phase decode
    wire         take      = hsel & htrans[1] & hready;
    wire         take_rd   = take & ~hwrite;
    wire         take_wr   = take & hwrite;

    // Write decode in the data phase
    wire         wr_ctrl   = wr_pend_q & (wr_addr_q == FIC_OFS_CONTROL);
    wire         wr_ctrl_ok = wr_ctrl & reg_unlocked;
    wire         wr_target = wr_pend_q & (wr_addr_q == FIC_OFS_TARGET);
    wire         wr_stat   = wr_pend_q & (wr_addr_q == FIC_OFS_INT_STAT);
    wire         wr_mask   = wr_pend_q & (wr_addr_q == FIC_OFS_INT_MASK);

    // Operation checks against the latched target
    wire fic_target_t tgt  = fic_region(target_q);
    wire         run_ldr   = boot_q;
    wire         wr_op     = prog_trigger.write_op;
    wire         fail_app  = (tgt == FIC_TGT_APP) & ~run_ldr & wr_op & ~app_uen_q;
    wire         fail_ldr  = (tgt == FIC_TGT_LDR) & wr_op & ~ldr_uen_q;
    wire         fail_cfg  = (tgt == FIC_TGT_CFG) & wr_op & ~cfg_uen_q;
    wire         fail_bad  = (tgt == FIC_TGT_BAD);
    wire         fail_any  = fail_app | fail_ldr | fail_cfg | fail_bad;

    // Trigger acceptance; a disabled function refuses the trigger but still raises the done event
    wire         trig_ok   = (state_q == FIC_ST_IDLE) & prog_trigger.start;
    wire         fail_set  = trig_ok & func_en_q & fail_any;
    wire         go        = trig_ok & func_en_q & ~fail_any;
    wire         op_end    = (state_q == FIC_ST_RUN) & flash_done;
    wire         drop      = trig_ok & ~func_en_q;

    // Set wins over a simultaneous write-one clear
    wire         fail_d    = fail_set | (fail_q & ~(wr_ctrl_ok & hwdata[FIC_BIT_FAIL]));

    // Interrupt events and their write-one clear
    wire [1:0]   ev        = {op_end | drop, fail_set};
    wire [1:0]   stat_clr  = wr_stat ? hwdata[1:0] : 2'h0;
    wire [1:0]   stat_d    = ev | (int_stat_q & ~stat_clr);

    // Register views; reserved bits read zero
    wire [31:0]  ctrl_view = {25'h0, fail_q, ldr_uen_q, cfg_uen_q, app_uen_q,
                              1'b0, boot_q, func_en_q};
    wire [31:0]  rd_mux    = (rd_addr_q == FIC_OFS_CONTROL)  ? ctrl_view :
                             (rd_addr_q == FIC_OFS_TARGET)   ? target_q :
                             (rd_addr_q == FIC_OFS_INT_STAT) ? {30'h0, int_stat_q} :
                             (rd_addr_q == FIC_OFS_INT_MASK) ? {30'h0, int_mask_q} :
                             32'h0000_0000;

    // Outputs straight from flops
    assign hreadyout   = hreadyout_q;
    assign hresp       = hresp_q;
    assign hrdata      = hrdata_q;
    assign flash_start = start_q;
    assign prog_busy   = busy_q;
    assign prog_enable = func_en_q;
    assign irq         = irq_q;

    // Bus phases: reads take one wait state so a preceding write is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_q   <= 1'b0;
            wr_pend_q   <= 1'b0;
            rd_addr_q   <= 8'h00;
            wr_addr_q   <= 8'h00;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end else begin
            rd_pend_q   <= take_rd;
            wr_pend_q   <= take_wr;
            hreadyout_q <= ~take_rd;
            if (take) begin
                rd_addr_q <= haddr[7:0];
                wr_addr_q <= haddr[7:0];
            end
        end
    end

    // Read data captured in the wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            hrdata_q <= rd_mux;
        end
    end

    // Protected control bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            func_en_q <= FIC_CONTROL_RST[FIC_BIT_FUNC_EN];
            app_uen_q <= FIC_CONTROL_RST[FIC_BIT_APP_UEN];
            cfg_uen_q <= FIC_CONTROL_RST[FIC_BIT_CFG_UEN];
            ldr_uen_q <= FIC_CONTROL_RST[FIC_BIT_LDR_UEN];
            fail_q    <= FIC_CONTROL_RST[FIC_BIT_FAIL];
        end else begin
            fail_q <= fail_d;
            // Locked writes are dropped without an error response
            if (wr_ctrl_ok) begin
                func_en_q <= hwdata[FIC_BIT_FUNC_EN];
                app_uen_q <= hwdata[FIC_BIT_APP_UEN];
                cfg_uen_q <= hwdata[FIC_BIT_CFG_UEN];
                ldr_uen_q <= hwdata[FIC_BIT_LDR_UEN];
            end
        end
    end

    // Boot-load marker: first edge after release loads the boot bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_init_q <= 1'b0;
        end else begin
            boot_init_q <= 1'b1;
        end
    end

    // Boot bit has no async reset so a processor or system reset keeps it
    always_ff @(posedge hclk) begin
        if (!boot_init_q && hresetn) begin
            if (!(cpu_reset_seen || system_reset_seen)) begin
                boot_q <= ~config_boot_choice[1];
            end
        end else if (wr_ctrl_ok) begin
            boot_q <= hwdata[FIC_BIT_BOOT_SEL];
        end
    end

    // Target address, unprotected
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            target_q <= FIC_TARGET_RST;
        end else if (wr_target) begin
            target_q <= hwdata;
        end
    end

    // Sequencer: check, start or fail, then wait for the array
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= FIC_ST_IDLE;
            start_q <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            start_q <= go;
            unique case (state_q)
                FIC_ST_IDLE: begin
                    // Failed checks never reach the array
                    if (go) begin
                        state_q <= FIC_ST_RUN;
                        busy_q  <= 1'b1;
                    end
                end
                FIC_ST_RUN: begin
                    // Trigger bit self-clears when the array finishes
                    if (flash_done) begin
                        state_q <= FIC_ST_IDLE;
                        busy_q  <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Interrupt status, mask and level output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_stat_q <= FIC_INT_RST;
            int_mask_q <= FIC_INT_RST;
            irq_q      <= 1'b0;
        end else begin
            int_stat_q <= stat_d;
            if (wr_mask) begin
                int_mask_q <= hwdata[1:0];
            end
            irq_q <= |(int_stat_q & int_mask_q);
        end
    end

    // Checks on the block's own behaviour
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    fail_app_a: assert property (trig_ok && func_en_q && tgt == FIC_TGT_APP && !boot_q
        && wr_op && !app_uen_q |=> fail_q && !start_q)
        else $error("application self-write did not fail");

    fail_ldr_a: assert property (trig_ok && func_en_q && tgt == FIC_TGT_LDR
        && wr_op && !ldr_uen_q |=> fail_q && state_q == FIC_ST_IDLE)
        else $error("loader write without enable did not fail");

    fail_cfg_a: assert property (trig_ok && func_en_q && tgt == FIC_TGT_CFG
        && wr_op && !cfg_uen_q |=> fail_q ##1 !start_q)
        else $error("config write without enable did not fail");

    bad_addr_a: assert property (trig_ok && func_en_q && target_q[1:0] != 2'h0
        |=> fail_q && !busy_q)
        else $error("misaligned target did not fail");

    fail_sticky_a: assert property (fail_q && !(wr_ctrl_ok && hwdata[FIC_BIT_FAIL])
        |=> fail_q)
        else $error("fail flag dropped without a clear");

    fail_clear_a: assert property (wr_ctrl_ok && hwdata[FIC_BIT_FAIL] && !fail_set
        |=> !fail_q)
        else $error("write one did not clear fail flag");

    lock_hold_a: assert property (wr_ctrl && !reg_unlocked
        |=> $stable({func_en_q, app_uen_q, cfg_uen_q, ldr_uen_q}))
        else $error("locked write changed control bits");

    start_busy_a: assert property (go |=> start_q && busy_q ##1 !start_q)
        else $error("start pulse or busy wrong");

    done_clear_a: assert property (busy_q && flash_done |=> !busy_q [*2])
        else $error("busy not cleared on completion");

    no_start_a: assert property (fail_set |=> !start_q && !busy_q)
        else $error("flash started on a failed check");

    rsvd_zero_a: assert property (rd_pend_q && rd_addr_q == FIC_OFS_CONTROL
        |=> hrdata_q[31:7] == 25'h0 && !hrdata_q[2] && hreadyout_q)
        else $error("reserved control bits read nonzero");

    enable_gate_a: assert property (trig_ok && !func_en_q |=> !start_q && !fail_q
        || $past(fail_q))
        else $error("disabled function acted on trigger");

    read_wait_a: assert property (take_rd |=> !hreadyout_q ##1 hreadyout_q)
        else $error("read wait state wrong");

endmodule : fic_ctrl_regs

// >>> inc/fic_pkg.sv
// Package: register map, field layout and region bounds of the flash programming control
package fic_pkg;

    // Register byte offsets
    localparam logic [7:0]  FIC_OFS_CONTROL   = 8'h00;
    localparam logic [7:0]  FIC_OFS_TARGET    = 8'h04;
    localparam logic [7:0]  FIC_OFS_INT_STAT  = 8'h20;
    localparam logic [7:0]  FIC_OFS_INT_MASK  = 8'h24;

    // Control register field positions
    localparam int          FIC_BIT_FUNC_EN   = 0;
    localparam int          FIC_BIT_BOOT_SEL  = 1;
    localparam int          FIC_BIT_APP_UEN   = 3;
    localparam int          FIC_BIT_CFG_UEN   = 4;
    localparam int          FIC_BIT_LDR_UEN   = 5;
    localparam int          FIC_BIT_FAIL      = 6;

    // Reset values
    localparam logic [31:0] FIC_CONTROL_RST   = 32'h0000_0000;
    localparam logic [31:0] FIC_TARGET_RST    = 32'h0000_0000;
    localparam logic [1:0]  FIC_INT_RST       = 2'h0;

    // Interrupt status and mask layout
    localparam int          FIC_IRQ_FAIL      = 0;
    localparam int          FIC_IRQ_DONE      = 1;

    // Flash geometry: 17K words of 32 bits
    localparam int unsigned FIC_FLASH_WORDS   = 17408;
    localparam logic [31:0] FIC_APP_LIMIT     = 32'(FIC_FLASH_WORDS * 4);
    localparam logic [31:0] FIC_LDR_BASE      = 32'h0010_0000;
    localparam logic [31:0] FIC_LDR_LIMIT     = 32'h0010_1000;
    localparam logic [31:0] FIC_CFG_BASE      = 32'h0030_0000;
    localparam logic [31:0] FIC_CFG_LIMIT     = 32'h0030_0008;

    // Region hit by a target address
    typedef enum logic [1:0] {
        FIC_TGT_APP = 2'b00,
        FIC_TGT_LDR = 2'b01,
        FIC_TGT_CFG = 2'b10,
        FIC_TGT_BAD = 2'b11
    } fic_target_t;

    // Sequencer states
    typedef enum logic {
        FIC_ST_IDLE = 1'b0,
        FIC_ST_RUN  = 1'b1
    } fic_state_t;

    // Trigger request from the command and trigger logic
    typedef struct packed {
        logic start;     // Software wrote 1 to the trigger bit
        logic write_op;  // Command is erase or program
    } fic_trig_t;

    // Classify a target address; misaligned words are illegal
    function automatic fic_target_t fic_region(input logic [31:0] a);
        fic_target_t r;
        r = FIC_TGT_BAD;
        if (a[1:0] != 2'h0) begin
            r = FIC_TGT_BAD;
        end else if (a < FIC_APP_LIMIT) begin
            r = FIC_TGT_APP;
        end else if (a >= FIC_LDR_BASE && a < FIC_LDR_LIMIT) begin
            r = FIC_TGT_LDR;
        end else if (a >= FIC_CFG_BASE && a < FIC_CFG_LIMIT) begin
            r = FIC_TGT_CFG;
        end
        return r;
    endfunction : fic_region

endpackage : fic_pkg

// >>> testbench/test_fic_ctrl_regs.sv
// Testbench: self-checking bench of the flash programming control registers
module test_fic_ctrl_regs
    import fic_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // Bus side and controller side stimulus
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        reg_unlocked;
    logic        cpu_reset_seen;
    logic        system_reset_seen;
    logic [1:0]  config_boot_choice;
    fic_trig_t   prog_trigger;
    logic        flash_done;
    logic        flash_start;
    logic        prog_busy;
    logic        prog_enable;
    logic        irq;
    int          n_mismatch = 0;   // Failed comparisons
    int          compares   = 0;   // All comparisons
    int          cycles     = 0;   // Hang guard
    logic [31:0] v;                // Raw read value

    // Register test row: lock state, address, write data, read-back
    typedef struct packed {
        logic        unl;
        logic [31:0] adr;
        logic [31:0] wd;
        logic [31:0] exp;
    } fic_rrow_t;
    // Trigger test row: control, target, op kind, fail, start
    typedef struct packed {
        logic [31:0] ctl;
        logic [31:0] adr;
        logic        wop;
        logic        fail;
        logic        go;
    } fic_trow_t;

    localparam fic_rrow_t RROWS [9] = '{
        '{1'b0, 32'h00, 32'hFFFF_FFFF, 32'h0000_0002},  // Locked: dropped
        '{1'b1, 32'h00, 32'hFFFF_FFFF, 32'h0000_003B},  // Reserved read zero
        '{1'b1, 32'h00, 32'h0000_0000, 32'h0000_0000},
        '{1'b0, 32'h00, 32'h0000_0011, 32'h0000_0000},
        '{1'b0, 32'h04, 32'h0001_0FFC, 32'h0001_0FFC},  // Target not protected
        '{1'b1, 32'h04, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
        '{1'b1, 32'h10, 32'h0000_FFFF, 32'h0000_0000},  // Unmapped
        '{1'b1, 32'h24, 32'h0000_0003, 32'h0000_0003},
        '{1'b1, 32'h24, 32'h0000_0000, 32'h0000_0000}
    };
    localparam fic_trow_t TROWS [11] = '{
        '{32'h01, 32'h0000_0100, 1'b1, 1'b1, 1'b0},  // App self-write, no enable
        '{32'h09, 32'h0000_0100, 1'b1, 1'b0, 1'b1},
        '{32'h03, 32'h0000_0100, 1'b1, 1'b0, 1'b1},  // App written from loader
        '{32'h03, 32'h0010_0000, 1'b1, 1'b1, 1'b0},  // Loader, no enable
        '{32'h23, 32'h0010_0000, 1'b1, 1'b0, 1'b1},
        '{32'h01, 32'h0030_0000, 1'b1, 1'b1, 1'b0},  // Config, no enable
        '{32'h11, 32'h0030_0004, 1'b1, 1'b0, 1'b1},
        '{32'h39, 32'h0001_1000, 1'b0, 1'b1, 1'b0},  // Just past flash end
        '{32'h39, 32'h0001_0FFC, 1'b1, 1'b0, 1'b1},  // Last word
        '{32'h39, 32'h0000_0102, 1'b0, 1'b1, 1'b0},  // Misaligned
        '{32'h00, 32'h0000_0100, 1'b1, 1'b0, 1'b0}   // Function disabled
    };

    // Ready is the one slave's own ready
    fic_ctrl_regs DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .reg_unlocked(reg_unlocked), .cpu_reset_seen(cpu_reset_seen),
        .system_reset_seen(system_reset_seen), .config_boot_choice(config_boot_choice),
        .prog_trigger(prog_trigger), .flash_done(flash_done), .flash_start(flash_start),
        .prog_busy(prog_busy), .prog_enable(prog_enable), .irq(irq)
    );

    // 250 MHz clock
    always #2 hclk = ~hclk;

    // Hang guard: 20000 cycles is ample for this run
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic chk_bit(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    // Single word transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= a;
        // Ready is stable from mid-cycle to the edge, so look at mid-cycle
        do @(negedge hclk); while (hreadyout !== 1'b1);
        @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(negedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(posedge hclk);
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] got;
        bus(1'b0, a, 32'h0, got);
        chk_word(nm, e, got);
    endtask : rd_chk

    // Reset with chosen boot field and cause flags
    task automatic do_reset(input logic [1:0] cbc, input logic cpu, input logic sys);
        hresetn            <= 1'b0;
        config_boot_choice <= cbc;
        cpu_reset_seen     <= cpu;
        system_reset_seen  <= sys;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask : do_reset

    // One trigger pulse, then completion of the array step if started
    task automatic trig(input logic wop, input logic go);
        prog_trigger <= '{start: 1'b1, write_op: wop};
        @(posedge hclk);
        prog_trigger <= '{start: 1'b0, write_op: 1'b0};
        @(negedge hclk);
        chk_bit("flash_start", go, flash_start);
        chk_bit("prog_busy", go, prog_busy);
        @(posedge hclk);
        if (go) begin
            @(negedge hclk);
            chk_bit("start_width", 1'b0, flash_start);
            repeat (2) @(posedge hclk);
            flash_done <= 1'b1;
            @(posedge hclk);
            flash_done <= 1'b0;
            @(negedge hclk);
            chk_bit("busy_clear", 1'b0, prog_busy);
            @(posedge hclk);
        end
    endtask : trig

    task automatic final_report;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // Main sequence
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        reg_unlocked = 1'b0;
        cpu_reset_seen = 1'b0;
        system_reset_seen = 1'b0;
        config_boot_choice = 2'b00;
        prog_trigger = '{start: 1'b0, write_op: 1'b0};
        flash_done = 1'b0;
        do_reset(2'b00, 1'b0, 1'b0);
        chk_bit("irq", 1'b0, irq);
        chk_bit("hresp", 1'b0, hresp);
        rd_chk("control", FIC_OFS_CONTROL, 32'h2);
        rd_chk("target", FIC_OFS_TARGET, 32'h0);
        // Register rows
        foreach (RROWS[i]) begin
            reg_unlocked <= RROWS[i].unl;
            wr(RROWS[i].adr, RROWS[i].wd);
            rd_chk("reg_row", RROWS[i].adr, RROWS[i].exp);
            if (RROWS[i].adr == 32'h0) begin
                chk_bit("prog_enable", RROWS[i].exp[0], prog_enable);
            end
        end
        // Trigger rows; each starts by clearing a stale fail
        reg_unlocked <= 1'b1;
        foreach (TROWS[i]) begin
            wr(FIC_OFS_CONTROL, TROWS[i].ctl | 32'h40);
            wr(FIC_OFS_TARGET, TROWS[i].adr);
            trig(TROWS[i].wop, TROWS[i].go);
            rd_chk("fail_row", FIC_OFS_CONTROL, TROWS[i].ctl | {TROWS[i].fail, 6'h0});
        end
        // Fail event, interrupt mask and clears
        wr(FIC_OFS_INT_STAT, 32'h3);
        wr(FIC_OFS_CONTROL, 32'h41);
        wr(FIC_OFS_TARGET, FIC_CFG_BASE);
        trig(1'b1, 1'b0);
        bus(1'b0, FIC_OFS_INT_STAT, 32'h0, v);
        chk_bit("fail_status", 1'b1, v[0]);
        chk_bit("irq_masked", 1'b0, irq);
        wr(FIC_OFS_INT_MASK, 32'h1);
        // Level output lags the mask write by one cycle
        @(posedge hclk);
        @(negedge hclk);
        chk_bit("irq_on", 1'b1, irq);
        @(posedge hclk);
        wr(FIC_OFS_CONTROL, 32'h01);
        rd_chk("fail_keep", FIC_OFS_CONTROL, 32'h41);
        reg_unlocked <= 1'b0;
        wr(FIC_OFS_CONTROL, 32'h40);
        rd_chk("fail_locked", FIC_OFS_CONTROL, 32'h41);
        reg_unlocked <= 1'b1;
        wr(FIC_OFS_CONTROL, 32'h41);
        rd_chk("fail_clear", FIC_OFS_CONTROL, 32'h01);
        wr(FIC_OFS_INT_STAT, 32'h1);
        // Level output lags the status clear by one cycle
        @(posedge hclk);
        @(negedge hclk);
        chk_bit("irq_off", 1'b0, irq);
        @(posedge hclk);
        // Boot bit across reset causes; it is 0 before these
        do_reset(2'b00, 1'b1, 1'b0);
        chk_bit("prog_enable_rst", 1'b0, prog_enable);
        rd_chk("boot_cpu", FIC_OFS_CONTROL, 32'h0);
        do_reset(2'b00, 1'b0, 1'b1);
        rd_chk("boot_sys", FIC_OFS_CONTROL, 32'h0);
        do_reset(2'b00, 1'b0, 1'b0);
        rd_chk("boot_pwr", FIC_OFS_CONTROL, 32'h2);
        do_reset(2'b10, 1'b0, 1'b0);
        rd_chk("boot_inv", FIC_OFS_CONTROL, 32'h0);
        final_report();
    end

endmodule : test_fic_ctrl_regs
